/* File: shared/pamux_pkg.sv */
/*
 Constants and types of the port A mux.
 Assumes a 100 MHz core clock and a 32-bit AHB-Lite bus.
*/
// What this block does
// - Pin 0 is a port bit, or the timer zero overflow pulse when selected.
// - The timer zero pulse is high for exactly one 24 MHz period per overflow, except overflows merged into one still pending, and low otherwise.
// - In split timer mode the timer zero pulse follows the low byte counter overflow.
// - Pin 1 is a port bit, or the timer one overflow pulse when selected.
// - The timer one pulse is high for exactly one 24 MHz period per overflow, except overflows merged into one still pending, and low otherwise.
// - In split timer mode the timer one pulse follows the low byte counter overflow.
// - Pin 2 is a port bit, or the active low memory output enable when selected.
// - Pin 3 is a port bit, or the active low memory chip select when selected.
// - Pin 4 is a port bit, or the external FIFO write strobe when selected.
// - Pin 5 is a port bit, or the external FIFO read strobe when selected.
// - The UART zero select resets to zero and when set routes UART zero data to pin 6.
// - Pin 6 carries UART zero data only in sync mode zero and is held at one otherwise.
// - The UART one select resets to zero and when set routes UART one data to pin 7.
// - Pin 7 carries UART one data in sync mode zero and is held at one in modes one to three.
// - The data bus moves bytes between endpoint FIFOs and the outside, timed by the FIFO strobes.
// - The data bus floats when idle, is input on reads, output on writes, and is driven low in suspend.
package pamux_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_PORT_OUT = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_PORT_DIR = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_FUNC_CFG = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_FUNC_CFG_ALT = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_FAST_STATUS = 8'h14;
    localparam logic [7:0] CFG_MASK = 8'h0F;
    localparam logic [7:0] CFG_ALT_MASK = 8'hF0;
    localparam int BIT_T0 = 0;
    localparam int BIT_T1 = 1;
    localparam int BIT_OE = 2;
    localparam int BIT_CS = 3;
    localparam int BIT_FWR = 4;
    localparam int BIT_FRD = 5;
    localparam int BIT_U0 = 6;
    localparam int BIT_U1 = 7;
    localparam int STAT_BUSY = 8;
    localparam int STAT_SUSPEND = 9;
    localparam logic [7:0] RST_PORT_OUT = 8'h00;
    localparam logic [7:0] RST_PORT_DIR = 8'h00;
    localparam logic [7:0] RST_FUNC_CFG = 8'h00;
    localparam logic [1:0] TIMER_SPLIT_MODE = 2'h3;
    localparam logic [1:0] UART_SYNC_MODE = 2'h0;
    localparam int CLK_MHZ = 100;
    localparam int OUT_CLK_MHZ = 24;
    localparam int STROBE_NS = 42;
    localparam int STROBE_CYCLES = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOVER_CYCLES = 2;
    localparam logic [3:0] STROBE_LOAD = 4'(STROBE_CYCLES - 1);
    localparam logic [3:0] RECOVER_LOAD = 4'(RECOVER_CYCLES - 1);
    typedef logic [7:0] pamux_byte_t;
    typedef enum logic [1:0] {
        FAST_IDLE = 2'b00,
        FAST_STROBE = 2'b01,
        FAST_RECOVER = 2'b11
    } pamux_fast_e;
endpackage

/* File: rtl/pamux_rate_tick.sv */
/*
 Rate tick: one pulse per 24 MHz output period.
 Assumes NUM below DEN; ticks come four or five clocks apart.
*/
`timescale 1ns/1ps
`default_nettype none
module pamux_rate_tick #(
    parameter int NUM = 24,
    parameter int DEN = 100,
    parameter int W = 7
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Tick
    output logic tick
);
    typedef struct packed {
        logic [W-1:0] acc;
        logic tick;
    } pamux_tick_s;
    pamux_tick_s cur_ff;
    pamux_tick_s nxt_cur;
    logic [W:0] sum;
    always_comb
    begin
        nxt_cur = cur_ff;
        sum = {1'b0, cur_ff.acc} + (W+1)'(NUM);
        nxt_cur.tick = 1'b0;
        if (sum >= (W+1)'(DEN))
        begin
            sum = sum - (W+1)'(DEN);
            nxt_cur.tick = 1'b1;
        end
        nxt_cur.acc = sum[W-1:0];
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cur_ff <= '0;
        else
            cur_ff <= nxt_cur;
    end
    assign tick = cur_ff.tick;
endmodule
`default_nettype wire

/* File: rtl/pamux_ovf_pulse.sv */
/*
 Stretches an overflow event to one output-clock period.
 Assumes its tick comes from the rate tick on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pamux_ovf_pulse (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Event side
    input wire logic tick,
    input wire logic overflowEvent,
    // Pulse
    output logic pulse
);
    typedef struct packed {
        logic pending;
        logic active;
    } pamux_pulse_s;
    pamux_pulse_s cur_ff;
    pamux_pulse_s nxt_cur;
    always_comb
    begin
        nxt_cur = cur_ff;
        // One event is held pending for a later period; further ones before its pulse merge into it
        nxt_cur.pending = cur_ff.pending | overflowEvent;
        if (tick)
        begin
            if (cur_ff.active)
                nxt_cur.active = 1'b0;
            else if (cur_ff.pending | overflowEvent)
            begin
                nxt_cur.active = 1'b1;
                nxt_cur.pending = cur_ff.pending & overflowEvent;
            end
        end
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cur_ff <= '0;
        else
            cur_ff <= nxt_cur;
    end
    assign pulse = cur_ff.active;
endmodule
`default_nettype wire

/* File: rtl/pamux_port_a.sv */
/*
 Port A pin mux: port registers, timer pulses,
 memory strobes, FIFO strobe engine, data bus
 and UART sync data outputs.
 Assumes one core clock; pins are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module pamux_port_a (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Timers
    input wire logic timer0Overflow,
    input wire logic timer0LowOverflow,
    input wire logic [1:0] timer0Mode,
    input wire logic timer1Overflow,
    input wire logic timer1LowOverflow,
    input wire logic [1:0] timer1Mode,
    // External memory strobes, active low
    input wire logic memOutputEnableN,
    input wire logic memChipSelectN,
    // UARTs
    input wire logic [1:0] uart0Mode,
    input wire logic uart0SyncData,
    input wire logic [1:0] uart1Mode,
    input wire logic uart1SyncData,
    // Fast transfer, endpoint FIFO side
    input wire logic fastWriteReq,
    input wire pamux_pkg::pamux_byte_t fastWriteByte,
    input wire logic fastReadReq,
    output logic fastBusy,
    output logic fastReadValid,
    output pamux_pkg::pamux_byte_t fastReadByte,
    // Power state
    input wire logic suspend,
    // Port A pins
    input wire logic [7:0] portAIn,
    output logic [7:0] portAOut,
    output logic [7:0] portAOeN,
    // Data bus pins
    input wire pamux_pkg::pamux_byte_t dataBusIn,
    output pamux_pkg::pamux_byte_t dataBusOut,
    output logic dataBusOeN,
    // Output clock tick
    output logic outputClock24mTick
);
    import pamux_pkg::*;

    typedef struct packed {
        logic [7:0] portOut;
        logic [7:0] portDir;
        logic [7:0] funcCfg;
        logic [7:0] pinSync1;
        logic [7:0] pinSync2;
        logic [7:0] busSync1;
        logic [7:0] busSync2;
        logic addrValid;
        logic addrWrite;
        logic [ADDR_W-1:0] addr;
        logic [31:0] rdata;
        pamux_fast_e fast;
        logic fastRead;
        logic [3:0] count;
        logic [7:0] busOut;
        logic busDrive;
        logic wrStrobeN;
        logic rdStrobeN;
        logic [7:0] readByte;
        logic readValid;
        logic [7:0] pinOut;
        logic [7:0] pinOeN;
    } pamux_state_s;

    pamux_state_s cur_ff;
    pamux_state_s nxt_cur;
    logic tick24;
    logic t0Event;
    logic t1Event;
    logic t0Pulse;
    logic t1Pulse;
    logic [7:0] altOut;
    logic [7:0] muxOut;
    logic [7:0] muxOeN;
    logic addrTake;
    logic wrAccept;
    logic rdAccept;

    pamux_rate_tick #(
        .NUM(OUT_CLK_MHZ),
        .DEN(CLK_MHZ),
        .W(7)
    ) u_tick (
        .clock(clock),
        .rst(rst),
        .tick(tick24)
    );

    assign t0Event = (timer0Mode == TIMER_SPLIT_MODE) ? timer0LowOverflow : timer0Overflow;
    assign t1Event = (timer1Mode == TIMER_SPLIT_MODE) ? timer1LowOverflow : timer1Overflow;

    pamux_ovf_pulse u_t0_pulse (
        .clock(clock),
        .rst(rst),
        .tick(tick24),
        .overflowEvent(t0Event),
        .pulse(t0Pulse)
    );

    pamux_ovf_pulse u_t1_pulse (
        .clock(clock),
        .rst(rst),
        .tick(tick24),
        .overflowEvent(t1Event),
        .pulse(t1Pulse)
    );

    always_comb
    begin
        altOut = 8'h00;
        altOut[BIT_T0] = t0Pulse;
        altOut[BIT_T1] = t1Pulse;
        altOut[BIT_OE] = memOutputEnableN;
        altOut[BIT_CS] = memChipSelectN;
        altOut[BIT_FWR] = cur_ff.wrStrobeN;
        altOut[BIT_FRD] = cur_ff.rdStrobeN;
        altOut[BIT_U0] = (uart0Mode == UART_SYNC_MODE) ? uart0SyncData : 1'b1;
        altOut[BIT_U1] = (uart1Mode == UART_SYNC_MODE) ? uart1SyncData : 1'b1;
    end

    // Selected functions always drive
    for (genvar i = 0; i < 8; i++)
    begin : g_pin
        assign muxOut[i] = cur_ff.funcCfg[i] ? altOut[i] : cur_ff.portOut[i];
        assign muxOeN[i] = cur_ff.funcCfg[i] ? 1'b0 : ~cur_ff.portDir[i];
    end

    assign addrTake = hsel && htrans[1] && hready;
    // Write wins; each needs its strobe selected
    assign wrAccept = (cur_ff.fast == FAST_IDLE) && !suspend && fastWriteReq && cur_ff.funcCfg[BIT_FWR];
    assign rdAccept = (cur_ff.fast == FAST_IDLE) && !suspend && fastReadReq && cur_ff.funcCfg[BIT_FRD]
        && !wrAccept;

    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.readValid = 1'b0;
        nxt_cur.pinSync1 = portAIn;
        nxt_cur.pinSync2 = cur_ff.pinSync1;
        nxt_cur.busSync1 = dataBusIn;
        nxt_cur.busSync2 = cur_ff.busSync1;
        nxt_cur.pinOut = muxOut;
        nxt_cur.pinOeN = muxOeN;

        // Data phase write
        if (cur_ff.addrValid && cur_ff.addrWrite)
        begin
            case (cur_ff.addr)
                ADDR_PORT_OUT: nxt_cur.portOut = hwdata[7:0];
                ADDR_PORT_DIR: nxt_cur.portDir = hwdata[7:0];
                ADDR_FUNC_CFG: nxt_cur.funcCfg = (cur_ff.funcCfg & CFG_ALT_MASK) | (hwdata[7:0] & CFG_MASK);
                ADDR_FUNC_CFG_ALT: nxt_cur.funcCfg = (cur_ff.funcCfg & CFG_MASK) | (hwdata[7:0] & CFG_ALT_MASK);
                default: nxt_cur.funcCfg = cur_ff.funcCfg;
            endcase
        end

        case (cur_ff.fast)
            FAST_IDLE:
            begin
                nxt_cur.busDrive = 1'b0;
                if (wrAccept)
                begin
                    nxt_cur.fast = FAST_STROBE;
                    nxt_cur.fastRead = 1'b0;
                    nxt_cur.busOut = fastWriteByte;
                    nxt_cur.busDrive = 1'b1;
                    nxt_cur.wrStrobeN = 1'b0;
                    nxt_cur.count = STROBE_LOAD;
                end
                else if (rdAccept)
                begin
                    nxt_cur.fast = FAST_STROBE;
                    nxt_cur.fastRead = 1'b1;
                    nxt_cur.rdStrobeN = 1'b0;
                    nxt_cur.count = STROBE_LOAD;
                end
            end
            FAST_STROBE:
            begin
                if (cur_ff.count == 4'h0)
                begin
                    nxt_cur.wrStrobeN = 1'b1;
                    nxt_cur.rdStrobeN = 1'b1;
                    nxt_cur.fast = FAST_RECOVER;
                    nxt_cur.count = RECOVER_LOAD;
                    if (cur_ff.fastRead)
                    begin
                        nxt_cur.readByte = cur_ff.busSync2;
                        nxt_cur.readValid = 1'b1;
                    end
                end
                else
                    nxt_cur.count = cur_ff.count - 4'h1;
            end
            FAST_RECOVER:
            begin
                // Write data held past the strobe edge at the pin
                if (cur_ff.count == 4'h0)
                begin
                    nxt_cur.fast = FAST_IDLE;
                    nxt_cur.busDrive = 1'b0;
                end
                else
                    nxt_cur.count = cur_ff.count - 4'h1;
            end
            default:
            begin
                nxt_cur.fast = FAST_IDLE;
                nxt_cur.busDrive = 1'b0;
                nxt_cur.wrStrobeN = 1'b1;
                nxt_cur.rdStrobeN = 1'b1;
            end
        endcase

        if (suspend)
        begin
            nxt_cur.busOut = 8'h00;
            nxt_cur.busDrive = 1'b1;
        end
        else if (cur_ff.fast == FAST_IDLE && !wrAccept)
            nxt_cur.busDrive = 1'b0;

        // Read data from next state: a write just ahead is seen
        nxt_cur.addrValid = addrTake;
        if (addrTake)
        begin
            nxt_cur.addrWrite = hwrite;
            nxt_cur.addr = haddr[ADDR_W-1:0];
        end
        nxt_cur.rdata = 32'h0000_0000;
        if (addrTake && !hwrite)
        begin
            case (haddr[ADDR_W-1:0])
                ADDR_PORT_OUT: nxt_cur.rdata = {24'h000000, nxt_cur.portOut};
                ADDR_PORT_DIR: nxt_cur.rdata = {24'h000000, nxt_cur.portDir};
                ADDR_FUNC_CFG: nxt_cur.rdata = {24'h000000, nxt_cur.funcCfg & CFG_MASK};
                ADDR_FUNC_CFG_ALT: nxt_cur.rdata = {24'h000000, nxt_cur.funcCfg & CFG_ALT_MASK};
                ADDR_PIN_LEVEL: nxt_cur.rdata = {24'h000000, cur_ff.pinSync2};
                ADDR_FAST_STATUS:
                begin
                    nxt_cur.rdata[7:0] = cur_ff.readByte;
                    nxt_cur.rdata[STAT_BUSY] = (cur_ff.fast != FAST_IDLE);
                    nxt_cur.rdata[STAT_SUSPEND] = suspend;
                end
                default: nxt_cur.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cur_ff <= '0;
            cur_ff.portOut <= RST_PORT_OUT;
            cur_ff.portDir <= RST_PORT_DIR;
            cur_ff.funcCfg <= RST_FUNC_CFG;
            cur_ff.fast <= FAST_IDLE;
            cur_ff.wrStrobeN <= 1'b1;
            cur_ff.rdStrobeN <= 1'b1;
            cur_ff.pinOeN <= 8'hFF;
        end
        else
            cur_ff <= nxt_cur;
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = cur_ff.rdata;
    assign fastBusy = (cur_ff.fast != FAST_IDLE);
    assign fastReadValid = cur_ff.readValid;
    assign fastReadByte = cur_ff.readByte;
    assign portAOut = cur_ff.pinOut;
    assign portAOeN = cur_ff.pinOeN;
    assign dataBusOut = cur_ff.busOut;
    assign dataBusOeN = ~cur_ff.busDrive;
    assign outputClock24mTick = tick24;
endmodule
`default_nettype wire

/* File: verification/pamux_port_a_props.sv */
/*
 Checker bound to pamux_port_a; sees its ports only.
 Assumes zero-wait writes, so shadows track the design.
*/
`timescale 1ns/1ps
`default_nettype none
module pamux_port_a_props (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // Sources
    input wire logic memOutputEnableN,
    input wire logic memChipSelectN,
    input wire logic [1:0] uart0Mode,
    input wire logic uart0SyncData,
    input wire logic [1:0] uart1Mode,
    input wire logic uart1SyncData,
    input wire logic suspend,
    // Outputs
    input wire logic fastBusy,
    input wire logic fastReadValid,
    input wire logic [7:0] portAOut,
    input wire logic [7:0] portAOeN,
    input wire pamux_pkg::pamux_byte_t dataBusOut,
    input wire logic dataBusOeN
);
    import pamux_pkg::*;
    logic apOn_ff;
    logic [7:0] apAddr_ff;
    logic [7:0] shadow_ff [4];
    logic [7:0] cfg;
    assign cfg = (shadow_ff[2] & CFG_MASK) | (shadow_ff[3] & CFG_ALT_MASK);
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            apOn_ff <= 1'b0;
            apAddr_ff <= 8'h00;
            shadow_ff <= '{default: 8'h00};
        end
        else
        begin
            apOn_ff <= hsel && htrans[1] && hready && hwrite;
            apAddr_ff <= haddr[7:0];
            if (apOn_ff && apAddr_ff[7:4] == 4'h0)
                shadow_ff[apAddr_ff[3:2]] <= hwdata[7:0];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    a_t0_pulse:
        assert property (cfg[0] && $past(cfg[0]) && $rose(portAOut[0]) |-> portAOut[0][*4] ##[1:2] !portAOut[0])
            else $error("Timer zero pulse length wrong");
    a_t1_pulse:
        assert property (cfg[1] && $past(cfg[1]) && $rose(portAOut[1]) |-> portAOut[1][*4] ##[1:2] !portAOut[1])
            else $error("Timer one pulse length wrong");
    a_mem_oe:
        assert property (cfg[2] && $past(cfg[2]) |-> portAOut[2] == $past(memOutputEnableN) && !portAOeN[2])
            else $error("Output enable pin wrong");
    a_mem_cs:
        assert property (cfg[3] && $past(cfg[3]) |-> portAOut[3] == $past(memChipSelectN) && !portAOeN[3])
            else $error("Chip select pin wrong");
    a_uart0_out:
        assert property (cfg[6] && $past(cfg[6]) |-> portAOut[6] == ($past(uart0Mode) == UART_SYNC_MODE
            ? $past(uart0SyncData) : 1'b1)) else $error("Uart zero pin wrong");
    a_uart1_out:
        assert property (cfg[7] && $past(cfg[7]) |-> portAOut[7] == ($past(uart1Mode) == UART_SYNC_MODE
            ? $past(uart1SyncData) : 1'b1)) else $error("Uart one pin wrong");
    a_gpio_pins:
        assert property (cfg == $past(cfg) |-> ((portAOut ^ $past(shadow_ff[0])) & ~cfg) == 8'h00
            && ((portAOeN ^ ~$past(shadow_ff[1])) & ~cfg) == 8'h00) else $error("Port bit drive wrong");
    a_write_strobe:
        assert property (cfg[4] && $fell(portAOut[4]) |-> !portAOut[4][*5] ##1 portAOut[4])
            else $error("Write strobe length wrong");
    a_write_drive:
        assert property (cfg[4] && $fell(portAOut[4]) |-> !dataBusOeN[*6])
            else $error("Data bus not driven for write");
    a_read_strobe:
        assert property (cfg[5] && $fell(portAOut[5]) |-> dataBusOeN ##4 fastReadValid)
            else $error("Read byte not delivered");
    a_suspend_low:
        assert property ($past(suspend) |-> !dataBusOeN && dataBusOut == 8'h00)
            else $error("Data bus not low in suspend");
    a_idle_float:
        assert property (!suspend && !$past(suspend) && !fastBusy |-> dataBusOeN)
            else $error("Data bus driven while idle");
endmodule
`default_nettype wire

/* File: verification/pamux_fifo_model.sv */
/*
 Board model: pull-ups on port A and an external FIFO.
 Assumes the bench supplies the byte offered to reads.
*/
`timescale 1ns/1ps
`default_nettype none
module pamux_fifo_model (
    // Block pins
    input wire logic [7:0] portAOut,
    input wire logic [7:0] portAOeN,
    input wire pamux_pkg::pamux_byte_t dataBusOut,
    input wire logic dataBusOeN,
    // Bench side
    input wire pamux_pkg::pamux_byte_t readByte,
    output pamux_pkg::pamux_byte_t wrByte,
    output int wrCount,
    // Levels back to the block
    output logic [7:0] portAIn,
    output pamux_pkg::pamux_byte_t dataBusIn
);
    import pamux_pkg::*;
    pamux_byte_t lastBus;
    // Pull-ups keep floating strobes inactive
    assign portAIn = portAOut | portAOeN;
    // Released bus never repeats the old byte
    assign dataBusIn = !dataBusOeN ? dataBusOut : (!portAIn[5] ? readByte : ~lastBus);
    initial
    begin
        lastBus = 8'h00;
        wrByte = 8'h00;
        wrCount = 0;
    end
    always @(negedge portAIn[5])
        lastBus = readByte;
    always @(posedge portAIn[4])
    begin
        if (!dataBusOeN)
        begin
            wrByte = dataBusOut;
            wrCount = wrCount + 1;
            lastBus = dataBusOut;
        end
    end
endmodule
`default_nettype wire

/* File: verification/pamux_port_a_tb_top.sv */
/*
 Self-checking bench for pamux_port_a.
 Assumes a 100 MHz clock and a zero-wait slave.
*/
`timescale 1ns/1ps
`default_nettype none
module pamux_port_a_tb_top;
    import pamux_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic tick;
    logic [3:0] ovf = 4'h0;
    logic [3:0] tMode = 4'h0;
    logic [1:0] mem = 2'b11;
    logic [1:0] uMode = 2'h0;
    logic [1:0] uData = 2'h0;
    logic fastWriteReq = 1'b0;
    logic fastReadReq = 1'b0;
    logic suspend = 1'b0;
    pamux_byte_t fastWriteByte = 8'h00;
    pamux_byte_t readByte = 8'h00;
    logic fastBusy;
    logic fastReadValid;
    pamux_byte_t fastReadByte;
    logic [7:0] portAIn;
    logic [7:0] portAOut;
    logic [7:0] portAOeN;
    pamux_byte_t dataBusIn;
    pamux_byte_t dataBusOut;
    logic dataBusOeN;
    pamux_byte_t wrByte;
    int wrCount;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    assign hready = hreadyout;
    always #5 clock = ~clock;
    pamux_port_a i_pamux_port_a (
        .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .timer0Overflow(ovf[0]), .timer0LowOverflow(ovf[1]), .timer0Mode(tMode[1:0]), .timer1Overflow(ovf[2]),
        .timer1LowOverflow(ovf[3]), .timer1Mode(tMode[3:2]), .memOutputEnableN(mem[0]), .memChipSelectN(mem[1]),
        .uart0Mode(uMode), .uart0SyncData(uData[0]), .uart1Mode(uMode), .uart1SyncData(uData[1]),
        .fastWriteReq(fastWriteReq), .fastWriteByte(fastWriteByte), .fastReadReq(fastReadReq),
        .fastBusy(fastBusy), .fastReadValid(fastReadValid), .fastReadByte(fastReadByte), .suspend(suspend),
        .portAIn(portAIn), .portAOut(portAOut), .portAOeN(portAOeN), .dataBusIn(dataBusIn),
        .dataBusOut(dataBusOut), .dataBusOeN(dataBusOeN), .outputClock24mTick(tick)
    );
    pamux_fifo_model i_pamux_fifo_model (
        .portAOut(portAOut), .portAOeN(portAOeN), .dataBusOut(dataBusOut), .dataBusOeN(dataBusOeN),
        .readByte(readByte), .wrByte(wrByte), .wrCount(wrCount), .portAIn(portAIn), .dataBusIn(dataBusIn)
    );
    task automatic give_verdict;
        $display("Checks %0d, errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdata);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hready !== 1'b1);
        rdata = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] got;
        bus(1'b0, a, 32'h0, got);
        check(got, exp, what);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic test_reset;
        check(portAOeN, 8'hFF, "pins float");
        rd(ADDR_FUNC_CFG, 32'h0, "config reset");
        rd(ADDR_FUNC_CFG_ALT, 32'h0, "alt config reset");
        rd(8'h40, 32'h0, "unmapped read");
    endtask
    task automatic test_tick;
        int n = 0;
        repeat (100)
        begin
            @(posedge clock);
            n += int'(tick);
        end
        check({hresp, 31'(n)}, 32'h18, "tick rate");
    endtask
    task automatic test_gpio;
        wr(ADDR_PORT_OUT, 32'hA5);
        wr(ADDR_PORT_DIR, 32'h0F);
        step(4);
        check({portAOeN, portAOut[3:0]}, 12'hF05, "port drive");
        rd(ADDR_PIN_LEVEL, 32'hF5, "pin level");
    endtask
    // One tick period is 4 or 5 clocks
    task automatic timer_pulse(input int t, input int low, input int lo);
        int n;
        n = 0;
        @(posedge clock);
        ovf <= 4'(1 << (2 * t + low));
        @(posedge clock);
        ovf <= 4'h0;
        repeat (14)
        begin
            @(posedge clock);
            n += int'(portAOut[t] === 1'b1);
        end
        check(32'(n >= lo && n <= lo + lo / 4), 32'h1, "timer pulse");
    endtask
    task automatic test_timers;
        wr(ADDR_FUNC_CFG, 32'h0F);
        timer_pulse(0, 0, 4);
        timer_pulse(1, 0, 4);
        tMode <= 4'hF;
        timer_pulse(0, 0, 0);
        timer_pulse(0, 1, 4);
        timer_pulse(1, 0, 0);
        timer_pulse(1, 1, 4);
        tMode <= 4'h0;
    endtask
    task automatic test_mem;
        for (int v = 0; v < 4; v++)
        begin
            @(posedge clock);
            mem <= 2'(v);
            step(3);
            check({portAOeN[3:2], portAOut[3:2]}, {2'b00, 2'(v)}, "memory strobes");
        end
    endtask
    task automatic test_uart;
        wr(ADDR_FUNC_CFG_ALT, 32'hC0);
        rd(ADDR_FUNC_CFG_ALT, 32'hC0, "alt config");
        for (int m = 0; m < 8; m++)
        begin
            @(posedge clock);
            uMode <= 2'(m >> 1);
            uData <= 2'(1 + (m & 1));
            step(3);
            check(portAOut[7:6], m < 2 ? 2'(1 + (m & 1)) : 2'b11, "uart pins");
        end
    endtask
    task automatic test_fast;
        int n;
        int base;
        wr(ADDR_FUNC_CFG_ALT, 32'h30);
        base = wrCount;
        @(posedge clock);
        fastWriteByte <= 8'h3C;
        fastWriteReq <= 1'b1;
        @(posedge clock);
        fastWriteReq <= 1'b0;
        @(posedge clock);
        fastWriteByte <= 8'hC3;
        fastWriteReq <= 1'b1;
        @(posedge clock);
        fastWriteReq <= 1'b0;
        step(8);
        check(wrByte, 8'h3C, "byte written");
        check(32'(wrCount - base), 32'h1, "write count");
        check(fastBusy, 1'b0, "busy after write");
        readByte <= 8'hA7;
        fastReadReq <= 1'b1;
        @(posedge clock);
        fastReadReq <= 1'b0;
        n = 0;
        while (fastReadValid !== 1'b1 && n < 20)
        begin
            @(posedge clock);
            n++;
        end
        check({fastReadByte, 1'b1}, {8'hA7, 1'(n < 20)}, "byte read");
        step(3);
        rd(ADDR_FAST_STATUS, 32'hA7, "status byte");
        suspend <= 1'b1;
        fastWriteReq <= 1'b1;
        step(3);
        check({fastBusy, dataBusOeN, dataBusOut}, 10'h000, "bus in suspend");
        fastWriteReq <= 1'b0;
        suspend <= 1'b0;
        step(3);
        check(dataBusOeN, 1'b1, "bus floats when idle");
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            $display("Error at %0t ns: timeout", $time);
            give_verdict();
        end
    end
    initial
    begin
        step(6);
        rst <= 1'b0;
        test_reset();
        test_tick();
        test_gpio();
        test_timers();
        test_mem();
        test_uart();
        test_fast();
        give_verdict();
    end
endmodule
bind pamux_port_a pamux_port_a_props i_pamux_port_a_props (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .memOutputEnableN(memOutputEnableN), .memChipSelectN(memChipSelectN),
    .uart0Mode(uart0Mode), .uart0SyncData(uart0SyncData), .uart1Mode(uart1Mode), .uart1SyncData(uart1SyncData),
    .suspend(suspend), .fastBusy(fastBusy), .fastReadValid(fastReadValid), .portAOut(portAOut),
    .portAOeN(portAOeN), .dataBusOut(dataBusOut), .dataBusOeN(dataBusOeN)
);
`default_nettype wire
